// *** hw/acs_pkg.sv ***
// Purpose: Constants for the active channel settings shadow registers
// Assumes: 200 MHz device clock
// Notes: Offsets are the register addresses as seen on the management bus
package acs_pkg;
	localparam logic [7:0] ACS_ADDR_ACTIVE_CHANNEL_DISABLE = 8'h22;
	localparam logic [7:0] ACS_ADDR_POL_ACT = 8'h23;
	localparam logic [7:0] ACS_DIS_RESET = 8'h00;
	localparam logic [7:0] ACS_POL_RESET = 8'h00;
	localparam int ACS_DIS_MSB = 7;
	localparam int ACS_DIS_LSB = 4;
	localparam logic [7:0] ACS_DIS_MASK = 8'hF0;
	localparam int ACS_SHUNT_MSB = 7;
	localparam int ACS_SHUNT_LSB = 4;
	localparam int ACS_SUPPLY_MSB = 3;
	localparam int ACS_SUPPLY_LSB = 0;
	localparam int ACS_CLK_MHZ = 200;
	localparam int ACS_VALID_TIME_US = 1000;
	localparam int ACS_VALID_CYCLES = ACS_VALID_TIME_US * ACS_CLK_MHZ;
	localparam int ACS_CNT_W = 18;
	typedef enum logic [1:0] {
		ACS_ST_VALID = 2'b01,
		ACS_ST_WAIT = 2'b10
	} acs_state_t;
endpackage

// *** hw/acs_shadow.sv ***
// Purpose: Active (applied) channel-disable and polarity shadow registers
// Assumes: Register reads and writes arrive as synchronous strobes from the bus front end
// Notes: On an apply strobe the polarity register captures its programmed copy and the disable register only bits 7:4 of its own
`timescale 1ns/10ps
module acs_shadow
	import acs_pkg::*;
#(
	parameter int VALID_CYCLES = ACS_VALID_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Apply command and programmed values
	input wire logic apply_i,
	input wire logic [7:0] prog_chan_disable_i,
	input wire logic [7:0] programmed_polarity_select_i,
	// Register access from the bus front end
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	// Active settings to the conversion sequencer
	output logic [3:0] chan_disable_o,
	output logic [3:0] shunt_bipolar_o,
	output logic [3:0] supply_bipolar_o,
	output logic settings_valid_o
);
	logic [7:0] dis_r, dis_nxt;
	logic [7:0] pol_r, pol_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic [ACS_CNT_W-1:0] cnt_r, cnt_nxt;
	acs_state_t st_r, st_nxt;
	logic [3:0] chan_disable_r, chan_disable_nxt;
	logic [3:0] shunt_r, shunt_nxt;
	logic [3:0] supply_r, supply_nxt;
	logic valid_r, valid_nxt;
	logic unused_w;

	// Shadow capture; writes never reach the stored bits
	always_comb begin
		dis_nxt = dis_r;
		pol_nxt = pol_r;
		if (apply_i) begin
			dis_nxt = prog_chan_disable_i & ACS_DIS_MASK;
			pol_nxt = programmed_polarity_select_i;
		end
		// Per-channel views follow the captured bytes on the same edge
		chan_disable_nxt = dis_nxt[ACS_DIS_MSB:ACS_DIS_LSB];
		shunt_nxt = pol_nxt[ACS_SHUNT_MSB:ACS_SHUNT_LSB];
		supply_nxt = pol_nxt[ACS_SUPPLY_MSB:ACS_SUPPLY_LSB];
	end

	// Validity timer started by each apply
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		unique case (st_r)
			ACS_ST_VALID: begin
				if (apply_i) begin
					st_nxt = ACS_ST_WAIT;
					cnt_nxt = ACS_CNT_W'(VALID_CYCLES - 1);
				end
			end
			ACS_ST_WAIT: begin
				if (apply_i) begin
					cnt_nxt = ACS_CNT_W'(VALID_CYCLES - 1);
				end else if (cnt_r == '0) begin
					st_nxt = ACS_ST_VALID;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			default: begin
				st_nxt = ACS_ST_VALID;
				cnt_nxt = '0;
			end
		endcase
		// Valid gets its own flop so the output needs no decode
		valid_nxt = (st_nxt == ACS_ST_VALID);
	end

	// Read data mux
	always_comb begin
		rdata_nxt = rdata_r;
		if (rd_i) begin
			unique case (addr_i)
				ACS_ADDR_ACTIVE_CHANNEL_DISABLE: rdata_nxt = dis_r & ACS_DIS_MASK;
				ACS_ADDR_POL_ACT: rdata_nxt = pol_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// Shadow group registers; reset clears every stored bit
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dis_r <= ACS_DIS_RESET;
			pol_r <= ACS_POL_RESET;
			chan_disable_r <= 4'h0;
			shunt_r <= 4'h0;
			supply_r <= 4'h0;
		end else begin
			dis_r <= dis_nxt;
			pol_r <= pol_nxt;
			chan_disable_r <= chan_disable_nxt;
			shunt_r <= shunt_nxt;
			supply_r <= supply_nxt;
		end
	end

	// Timer group registers; a reset in mid-interval leaves the shadows valid
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_r <= '0;
			st_r <= ACS_ST_VALID;
			valid_r <= 1'b1;
		end else begin
			cnt_r <= cnt_nxt;
			st_r <= st_nxt;
			valid_r <= valid_nxt;
		end
	end

	// Read data register; holds the last read until the next one
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// Write data is accepted and dropped
	assign unused_w = wr_i & (|wdata_i);
	assign rdata_o = rdata_r;
	assign chan_disable_o = chan_disable_r;
	assign shunt_bipolar_o = shunt_r;
	assign supply_bipolar_o = supply_r;
	assign settings_valid_o = valid_r;

	// Checks
	property p_dis_hold;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		!apply_i |=> $stable(dis_r);
	endproperty
	a_dis_hold: assert property (p_dis_hold) else $error("disable shadow moved without apply");

	property p_dis_load;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		apply_i |=> dis_r == ($past(prog_chan_disable_i) & ACS_DIS_MASK);
	endproperty
	a_dis_load: assert property (p_dis_load) else $error("disable shadow load wrong");

	property p_dis_low;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		rd_i && addr_i == ACS_ADDR_ACTIVE_CHANNEL_DISABLE |=> rdata_o[3:0] == 4'h0;
	endproperty
	a_dis_low: assert property (p_dis_low) else $error("unused disable bits read nonzero");

	property p_pol_load;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		apply_i |=> pol_r == $past(programmed_polarity_select_i);
	endproperty
	a_pol_load: assert property (p_pol_load) else $error("polarity shadow load wrong");

	property p_pol_hold;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		!apply_i |=> $stable(pol_r);
	endproperty
	a_pol_hold: assert property (p_pol_hold) else $error("polarity shadow moved without apply");

	// Polarity reads return the full applied byte
	property p_pol_read;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		rd_i && addr_i == ACS_ADDR_POL_ACT |=> rdata_o == $past(pol_r);
	endproperty
	a_pol_read: assert property (p_pol_read) else $error("polarity read wrong");

	// Host writes never disturb either shadow
	property p_wr_ignored;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		wr_i && !apply_i |=> $stable(dis_r) && $stable(pol_r);
	endproperty
	a_wr_ignored: assert property (p_wr_ignored) else $error("write altered shadow");

	property p_chan_map;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		chan_disable_o == dis_r[7:4];
	endproperty
	a_chan_map: assert property (p_chan_map) else $error("channel disable map wrong");

	property p_shunt_map;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		shunt_bipolar_o == pol_r[7:4];
	endproperty
	a_shunt_map: assert property (p_shunt_map) else $error("shunt format map wrong");

	property p_supply_map;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		supply_bipolar_o == pol_r[3:0];
	endproperty
	a_supply_map: assert property (p_supply_map) else $error("supply format map wrong");

	sequence s_apply;
		apply_i;
	endsequence
	property p_valid_drop;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		s_apply |=> !settings_valid_o;
	endproperty
	a_valid_drop: assert property (p_valid_drop) else $error("valid not cleared by apply");

	property p_valid_cnt;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		(st_r == ACS_ST_WAIT && cnt_r == '0 && !apply_i) |=> settings_valid_o;
	endproperty
	a_valid_cnt: assert property (p_valid_cnt) else $error("valid not restored after interval");

	// Valid stays low past the first cycle of the interval
	sequence s_apply_quiet;
		apply_i ##1 !apply_i;
	endsequence
	property p_valid_low2;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		s_apply_quiet |=> !settings_valid_o;
	endproperty
	a_valid_low2: assert property (p_valid_low2) else $error("valid rose too early");
endmodule

// *** verif/acs_host_model.sv ***
// Purpose: Host side register master
// Assumes: Strobes change at the falling edge
// Notes: Address and data are inverted when idle
`timescale 1ns/10ps
module acs_host_model (
	// Clock
	input wire logic sys_clk_i,
	// Access strobes
	output logic rd_o,
	output logic wr_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o
);
	initial begin
		rd_o = 1'b0;
		wr_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end
	// One-cycle read or write
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk_i);
		rd_o = !w;
		wr_o = w;
		addr_o = a;
		wdata_o = d;
		@(negedge sys_clk_i);
		rd_o = 1'b0;
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask
endmodule

// *** verif/tb_acs_shadow.sv ***
// Purpose: Self-checking bench for acs_shadow
// Assumes: Valid time shortened to 10 cycles
// Notes: Model keeps the applied copies in integers
`timescale 1ns/10ps
module tb_acs_shadow;
	import acs_pkg::*;
	localparam int VC = 10;
	logic sys_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic apply_i = 1'b0;
	logic [7:0] pdis = 8'h00;
	logic [7:0] ppol = 8'h00;
	logic rd, wr, valid_o;
	logic [7:0] addr, wdata, rdata_o;
	logic [3:0] dis_o, shb_o, sub_o;
	int mismatches = 0;
	int check_count = 0;
	int cycles = 0;
	int seed = 28;
	int m_dis = 0;
	int m_pol = 0;
	initial forever #2.5 sys_clk_i = ~sys_clk_i;
	acs_host_model i_acs_host_model (.sys_clk_i(sys_clk_i), .rd_o(rd), .wr_o(wr),
		.addr_o(addr), .wdata_o(wdata));
	acs_shadow #(.VALID_CYCLES(VC)) i_acs_shadow (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
		.apply_i(apply_i), .prog_chan_disable_i(pdis), .programmed_polarity_select_i(ppol),
		.rd_i(rd), .wr_i(wr), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata_o),
		.chan_disable_o(dis_o), .shunt_bipolar_o(shb_o), .supply_bipolar_o(sub_o),
		.settings_valid_o(valid_o));
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task end_sim;
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Read both shadows, an unmapped place and the outputs
	task rd_all;
		i_acs_host_model.acc(1'b0, ACS_ADDR_ACTIVE_CHANNEL_DISABLE, 8'h00);
		chk(rdata_o, 8'(m_dis));
		i_acs_host_model.acc(1'b0, ACS_ADDR_POL_ACT, 8'h00);
		chk(rdata_o, 8'(m_pol));
		i_acs_host_model.acc(1'b0, 8'h24, 8'h00);
		chk(rdata_o, 8'h00);
		chk({dis_o, shb_o}, {m_dis[7:4], m_pol[7:4]});
		chk({4'h0, sub_o}, 8'(m_pol[3:0]));
	endtask
	// Apply fresh random programmed values; valid must drop next cycle
	task do_apply;
		@(negedge sys_clk_i);
		pdis = 8'($random(seed));
		ppol = 8'($random(seed));
		apply_i = 1'b1;
		m_dis = pdis & ACS_DIS_MASK;
		m_pol = ppol;
		@(negedge sys_clk_i);
		apply_i = 1'b0;
		chk({7'h00, valid_o}, 8'h00);
	endtask
	// Valid still low on the last cycle of the interval, high just after
	task wait_valid;
		repeat (VC - 1) @(negedge sys_clk_i);
		chk({7'h00, valid_o}, 8'h00);
		@(negedge sys_clk_i);
		chk({7'h00, valid_o}, 8'h01);
	endtask
	// Cycle ceiling
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles > 5000) begin
			mismatches++;
			end_sim();
		end
	end
	initial begin
		repeat (4) @(negedge sys_clk_i);
		rstn_i = 1'b1;
		chk({7'h00, valid_o}, 8'h01);
		rd_all();
		$display("reset test done");
		for (int i = 0; i < 40; i++) begin
			if (i % 3 == 0) begin
				do_apply();
				wait_valid();
			end else begin
				@(negedge sys_clk_i);
				pdis = 8'($random(seed));
				ppol = 8'($random(seed));
			end
			i_acs_host_model.acc(1'b1, ACS_ADDR_ACTIVE_CHANNEL_DISABLE + i[0], pdis);
			rd_all();
		end
		$display("apply and access test done");
		// A second apply inside the interval restarts it
		do_apply();
		repeat (3) @(negedge sys_clk_i);
		do_apply();
		wait_valid();
		rd_all();
		$display("apply restart test done");
		// Reset in mid-interval clears the shadows and the timer
		do_apply();
		rstn_i = 1'b0;
		m_dis = 0;
		m_pol = 0;
		@(negedge sys_clk_i);
		chk({dis_o, shb_o}, 8'h00);
		chk({4'h0, sub_o}, 8'h00);
		rstn_i = 1'b1;
		chk({7'h00, valid_o}, 8'h01);
		rd_all();
		$display("mid-run reset test done");
		end_sim();
	end
endmodule
